/* File: sbds_pkg.sv */
// shared constants and types of the sideband discovery sequencer
package sbds_pkg;
  // widths of ids and data on the link
  localparam int unsigned PKG_W = 3; // package id width
  localparam int unsigned CH_W = 2; // internal channel id width
  localparam int unsigned NUM_PKG = 8; // package ids probed
  localparam int unsigned NUM_CH = 4; // channel ids probed per package
  localparam int unsigned DATA_W = 8; // pass-through data width
  localparam int unsigned AEN_W = 4; // event notification code width
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 5; // 200 MHz sys_clk
  localparam int unsigned PWRUP_US = 2000; // controller ready interval
  localparam int unsigned PWRUP_CYC =
    (PWRUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RSP_US = 50; // response time limit
  localparam int unsigned RSP_CYC = (RSP_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TRIES = 3; // attempts before giving up
  // reset values
  localparam logic ARB_OK_RST = 1'b1; // arbitration assumed until denied
  // command codes on the control channel
  typedef enum logic [2:0] {
    CMD_CIS = 3'h0, // clear initial state, also the probe
    CMD_SELECT = 3'h1, // select package
    CMD_DESELECT = 3'h2, // deselect package
    CMD_GET_CAPS = 3'h3, // get capabilities
    CMD_AEN_EN = 3'h4, // enable event notifications
    CMD_ENABLE_CH = 3'h5 // enable channel
  } sbds_cmd_e;
endpackage : sbds_pkg

/* File: sbds_link_if.sv */
// sideband link between the management end and a controller end
`timescale 1ns/1ps
interface sbds_link_if;
  import sbds_pkg::*;
  // control traffic, management to controller
  logic cmd_valid; // one-cycle command strobe
  sbds_cmd_e cmd_code; // command code
  logic [PKG_W-1:0] cmd_pkg; // target package id
  logic [CH_W-1:0] cmd_ch; // target channel id
  logic cmd_arb; // arbitration parameter of select
  // control traffic, controller to management
  logic rsp_valid; // one-cycle response strobe
  logic [PKG_W-1:0] rsp_pkg; // responding package id
  logic [CH_W-1:0] rsp_ch; // responding channel id
  logic rsp_arb; // arbitration supported and in use
  logic aen_valid; // one-cycle event notification
  logic [PKG_W-1:0] aen_pkg; // notifying package id
  logic [AEN_W-1:0] aen_code; // event code
  // pass-through traffic, kept apart from control
  logic pt_tx_valid; // management to network
  logic [DATA_W-1:0] pt_tx_data; // byte to network
  logic pt_rx_valid; // network to management
  logic [DATA_W-1:0] pt_rx_data; // byte from network
  modport mgmt (
    output cmd_valid, cmd_code, cmd_pkg, cmd_ch, cmd_arb,
    output pt_tx_valid, pt_tx_data,
    input rsp_valid, rsp_pkg, rsp_ch, rsp_arb,
    input aen_valid, aen_pkg, aen_code, pt_rx_valid, pt_rx_data
  );
  modport nc (
    input cmd_valid, cmd_code, cmd_pkg, cmd_ch, cmd_arb,
    input pt_tx_valid, pt_tx_data,
    output rsp_valid, rsp_pkg, rsp_ch, rsp_arb,
    output aen_valid, aen_pkg, aen_code, pt_rx_valid, pt_rx_data
  );
endinterface : sbds_link_if

/* File: sbds_nc_end.sv */
// controller end: answers commands, sends events, forwards pass-through
`timescale 1ns/1ps
module sbds_nc_end import sbds_pkg::*; #(
  parameter logic [PKG_W-1:0] PKG_ID = 3'h0, // this package id
  parameter int unsigned CH_NUM = 2, // channels present, at most NUM_CH
  parameter logic ARB_CAP = 1'b1 // supports hardware arbitration
) (
  input wire logic sys_clk, // system clock
  input wire logic reset_n, // async reset, active low
  sbds_link_if.nc link, // sideband link
  input wire logic net_rx_valid, // byte from network
  input wire logic [DATA_W-1:0] net_rx_data, // network byte
  output logic net_tx_valid, // byte to network
  output logic [DATA_W-1:0] net_tx_data, // network byte
  input wire logic event_valid, // local event pulse
  input wire logic [CH_W-1:0] event_ch, // channel of the event
  input wire logic [AEN_W-1:0] event_code, // event code
  output logic selected, // package selected
  output logic arb_en, // arbitration in use
  output logic [NUM_CH-1:0] ch_enabled, // channels enabled
  output logic [NUM_CH-1:0] ch_initial // channels in initial state
);
  logic [NUM_CH-1:0] aen_en; // event notifications enabled
  logic next_selected, next_arb_en; // next package state
  logic [NUM_CH-1:0] next_ch_enabled, next_ch_initial, next_aen_en;
  logic next_rsp_valid, next_rsp_arb; // next response
  logic [PKG_W-1:0] next_rsp_pkg; // next response package
  logic [CH_W-1:0] next_rsp_ch; // next response channel
  logic next_aen_valid; // next event strobe
  logic [AEN_W-1:0] next_aen_code; // next event code
  logic next_pt_rx_valid, next_net_tx_valid; // next pass-through
  logic [DATA_W-1:0] next_pt_rx_data, next_net_tx_data;
  logic hit, pkg_cmd, ch_ok, fwd; // decode helpers

  // command decode, effects and answers
  always_comb begin
    next_selected = selected;
    next_arb_en = arb_en;
    next_ch_enabled = ch_enabled;
    next_ch_initial = ch_initial;
    next_aen_en = aen_en;
    hit = link.cmd_valid && (link.cmd_pkg == PKG_ID);
    pkg_cmd = (link.cmd_code == CMD_SELECT) ||
              (link.cmd_code == CMD_DESELECT);
    ch_ok = 32'(link.cmd_ch) < CH_NUM; // missing channels stay silent
    // only a command draws a response
    next_rsp_valid = hit && (pkg_cmd || ch_ok);
    next_rsp_pkg = PKG_ID;
    next_rsp_ch = link.cmd_ch;
    next_rsp_arb = ARB_CAP & arb_en;
    if (next_rsp_valid) begin
      unique case (link.cmd_code)
        CMD_CIS: begin
          next_ch_initial[link.cmd_ch] = 1'b0; // channel leaves init
          next_selected = 1'b1; // addressing implicitly selects
        end
        CMD_GET_CAPS: begin
          next_selected = 1'b1; // query implicitly selects
        end
        CMD_SELECT: begin
          next_selected = 1'b1;
          next_arb_en = link.cmd_arb & ARB_CAP; // may switch arb off
        end
        CMD_DESELECT: begin
          next_selected = 1'b0; // deselect stops pass-through unless arbitration is in use
        end
        CMD_AEN_EN: begin
          next_aen_en[link.cmd_ch] = 1'b1;
        end
        CMD_ENABLE_CH: begin
          next_ch_enabled[link.cmd_ch] = 1'b1;
        end
        default: begin
          next_rsp_valid = 1'b0; // unknown code ignored
        end
      endcase
    end
    // events go out only for enabled channels
    next_aen_valid = event_valid && (32'(event_ch) < CH_NUM) &&
                     aen_en[event_ch] && ch_enabled[event_ch];
    next_aen_code = event_code;
    // pass-through needs an enabled channel and the right to drive
    fwd = (selected || arb_en) && (|ch_enabled);
    next_pt_rx_valid = net_rx_valid && fwd;
    next_pt_rx_data = net_rx_data;
    next_net_tx_valid = link.pt_tx_valid && fwd;
    next_net_tx_data = link.pt_tx_data;
  end

  // register all state; arbitration defaults on when supported
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      selected <= 1'b0;
      arb_en <= ARB_CAP;
      ch_enabled <= '0;
      ch_initial <= '1;
      aen_en <= '0;
      link.rsp_valid <= 1'b0;
      link.rsp_pkg <= '0;
      link.rsp_ch <= '0;
      link.rsp_arb <= 1'b0;
      link.aen_valid <= 1'b0;
      link.aen_pkg <= '0;
      link.aen_code <= '0;
      link.pt_rx_valid <= 1'b0;
      link.pt_rx_data <= '0;
      net_tx_valid <= 1'b0;
      net_tx_data <= '0;
    end else begin
      selected <= next_selected;
      arb_en <= next_arb_en;
      ch_enabled <= next_ch_enabled;
      ch_initial <= next_ch_initial;
      aen_en <= next_aen_en;
      link.rsp_valid <= next_rsp_valid;
      link.rsp_pkg <= next_rsp_pkg;
      link.rsp_ch <= next_rsp_ch;
      link.rsp_arb <= next_rsp_arb;
      link.aen_valid <= next_aen_valid;
      link.aen_pkg <= PKG_ID;
      link.aen_code <= next_aen_code;
      link.pt_rx_valid <= next_pt_rx_valid;
      link.pt_rx_data <= next_pt_rx_data;
      net_tx_valid <= next_net_tx_valid;
      net_tx_data <= next_net_tx_data;
    end
  end
endmodule : sbds_nc_end

/* File: sbds_mgmt_end.sv */
// management end: discovers, queries, configures and enables channels
// Function
// - management side originates every command
// - controller events only when enabled
// - pass-through kept apart from control traffic
// - control traffic: commands, responses, events
// - known arbitration: discover with probe only
// - probe from lowest package and channel
// - channel silence ends that package's channels
// - silent channel zero means package absent
// - response marks channel and package present
// - query capabilities of every found channel
// - after discovery enable events then channels
// - arbitration allows any configuration order
// - unknown arbitration: learn it by query
// - unknown arbitration: deselect after each package
// - all controllers arbitrating means arbitration active
// - any refusal or silence means inactive
// - inactive: at most one package selected
// - inactive: select with arbitration disabled
// - wait ready interval before first command
// - retry silent commands, three tries total
`timescale 1ns/1ps
module sbds_mgmt_end import sbds_pkg::*; #(
  parameter int unsigned NPKG = NUM_PKG, // package ids to probe
  parameter int unsigned NCH = NUM_CH, // channel ids per package
  parameter int unsigned PWRUP_CYCLES = PWRUP_CYC, // ready wait
  parameter int unsigned RSP_CYCLES = RSP_CYC, // response timeout
  parameter int unsigned MAX_TRIES = TRIES // attempts per command
) (
  input wire logic sys_clk, // system clock
  input wire logic reset_n, // async reset, active low
  sbds_link_if.mgmt link, // sideband link
  input wire logic arb_known, // arbitration known to be in use
  input wire logic pt_out_valid, // byte for the network
  input wire logic [DATA_W-1:0] pt_out_data, // outgoing byte
  output logic pt_in_valid, // byte from the network
  output logic [DATA_W-1:0] pt_in_data, // incoming byte
  output logic aen_seen, // event notification pulse
  output logic [PKG_W-1:0] aen_pkg_seen, // notifying package
  output logic [AEN_W-1:0] aen_code_seen, // event code
  output logic done, // sequence finished
  output logic arb_active, // arbitration regarded active
  output logic [NPKG-1:0] pkg_present, // packages found
  output logic [NPKG*NCH-1:0] ch_present // channels found
);
  typedef enum logic [5:0] {
    S_PWR = 6'h01, // waiting out the ready interval
    S_SEND = 6'h02, // issuing the current command
    S_WAIT = 6'h04, // waiting for its response
    S_CFG = 6'h08, // picking the next package to configure
    S_CH = 6'h10, // picking the next channel to configure
    S_DONE = 6'h20 // inventory reported
  } sbds_mst_e;

  localparam logic [PKG_W-1:0] PKG_LAST = PKG_W'(NPKG - 1);
  localparam logic [CH_W-1:0] CH_LAST = CH_W'(NCH - 1);

  sbds_mst_e st, next_st; // sequencer state
  sbds_cmd_e cmd, next_cmd; // command in flight
  logic [PKG_W-1:0] pkg, next_pkg; // current package id
  logic [CH_W-1:0] ch, next_ch; // current channel id
  logic [3:0] tries, next_tries; // failed attempts so far
  logic [31:0] tmr, next_tmr; // wait and timeout counter
  logic cfg_phase, next_cfg_phase; // 0 discovery, 1 configuration
  logic [NPKG-1:0] arb_ok, next_arb_ok; // per package arbitration
  logic next_arb_active, next_done;
  logic [NPKG-1:0] next_pkg_present;
  logic [NPKG*NCH-1:0] next_ch_present;
  logic next_cmd_valid, next_cmd_arb; // link command fields
  sbds_cmd_e next_cmd_code;
  logic [PKG_W-1:0] next_cmd_pkg;
  logic [CH_W-1:0] next_cmd_ch;
  logic got, lost; // answer seen or attempts exhausted
  logic do_adv, do_pkg_end, do_ch_next, do_cfg_next; // step flags

  // flat inventory index of a package and channel
  function automatic int unsigned slot(input logic [PKG_W-1:0] p,
                                       input logic [CH_W-1:0] c);
    return 32'(p) * NCH + 32'(c);
  endfunction : slot

  // sequencer: one command outstanding at a time
  always_comb begin
    next_st = st;
    next_cmd = cmd;
    next_pkg = pkg;
    next_ch = ch;
    next_tries = tries;
    next_tmr = tmr;
    next_cfg_phase = cfg_phase;
    next_arb_ok = arb_ok;
    next_arb_active = arb_active;
    next_done = done;
    next_pkg_present = pkg_present;
    next_ch_present = ch_present;
    next_cmd_valid = 1'b0;
    next_cmd_code = link.cmd_code;
    next_cmd_pkg = link.cmd_pkg;
    next_cmd_ch = link.cmd_ch;
    next_cmd_arb = link.cmd_arb;
    got = 1'b0;
    lost = 1'b0;
    do_adv = 1'b0;
    do_pkg_end = 1'b0;
    do_ch_next = 1'b0;
    do_cfg_next = 1'b0;
    unique case (st)
      S_PWR: begin
        // nothing is sent before controllers can answer
        next_tmr = tmr + 32'h1;
        if (tmr >= PWRUP_CYCLES - 1) begin
          next_cmd = CMD_CIS;
          next_pkg = '0;
          next_ch = '0;
          next_st = S_SEND;
        end
      end
      S_SEND: begin
        // this end is the only initiator on the link
        next_cmd_valid = 1'b1;
        next_cmd_code = cmd;
        next_cmd_pkg = pkg;
        next_cmd_ch = ch;
        next_cmd_arb = 1'b0; // select always disables arbitration
        next_tmr = '0;
        next_st = S_WAIT;
      end
      S_WAIT: begin
        next_tmr = tmr + 32'h1;
        if (link.rsp_valid && link.rsp_pkg == pkg &&
            link.rsp_ch == ch) begin
          got = 1'b1;
          next_tries = '0;
        end else if (tmr >= RSP_CYCLES - 1) begin
          // same command again until the tries run out
          if (32'(tries) >= MAX_TRIES - 1) begin
            lost = 1'b1;
            next_tries = '0;
          end else begin
            next_tries = tries + 4'h1;
            next_st = S_SEND;
          end
        end
        if (got || lost) begin
          unique case (cmd)
            CMD_CIS: begin
              if (got) begin
                next_pkg_present[pkg] = 1'b1;
                next_ch_present[slot(pkg, ch)] = 1'b1;
                // query right away so no channel is skipped
                next_cmd = CMD_GET_CAPS;
                next_st = S_SEND;
              end else if (ch == '0) begin
                do_adv = 1'b1; // package id unpopulated
              end else begin
                do_pkg_end = 1'b1; // no further channels
              end
            end
            CMD_GET_CAPS: begin
              // silence counts as lacking arbitration
              next_arb_ok[pkg] = arb_ok[pkg] & got & link.rsp_arb;
              if (ch == CH_LAST) begin
                do_pkg_end = 1'b1;
              end else begin
                next_ch = ch + CH_W'(1); // probe upward
                next_cmd = CMD_CIS;
                next_st = S_SEND;
              end
            end
            CMD_DESELECT: begin
              if (cfg_phase) begin
                do_cfg_next = 1'b1;
              end else begin
                do_adv = 1'b1;
              end
            end
            CMD_SELECT: begin
              next_ch = '0;
              next_st = S_CH;
            end
            CMD_AEN_EN: begin
              next_cmd = CMD_ENABLE_CH; // events enabled, then channel enabled
              next_st = S_SEND;
            end
            CMD_ENABLE_CH: begin
              do_ch_next = 1'b1;
            end
            default: begin
              next_st = S_DONE; // corrupt command code
            end
          endcase
        end
      end
      S_CFG: begin
        if (!pkg_present[pkg]) begin
          do_cfg_next = 1'b1;
        end else if (!arb_active) begin
          next_cmd = CMD_SELECT; // one package at a time
          next_st = S_SEND;
        end else begin
          // with arbitration no select is needed
          next_ch = '0;
          next_st = S_CH;
        end
      end
      S_CH: begin
        if (ch_present[slot(pkg, ch)]) begin
          next_cmd = CMD_AEN_EN;
          next_st = S_SEND;
        end else begin
          do_ch_next = 1'b1;
        end
      end
      S_DONE: begin
        next_done = 1'b1;
      end
      default: begin
        next_st = S_DONE; // illegal state code
      end
    endcase
    // end of a package during discovery
    if (do_pkg_end) begin
      if (!arb_known) begin
        next_cmd = CMD_DESELECT;
        next_st = S_SEND;
      end else begin
        do_adv = 1'b1; // probe only, no select or deselect
      end
    end
    // next package id during discovery
    if (do_adv) begin
      next_ch = '0;
      if (pkg == PKG_LAST) begin
        // last id tried: settle arbitration, start configuring
        next_arb_active = arb_known || ((|next_pkg_present) &&
          (&(next_arb_ok | ~next_pkg_present)));
        next_cfg_phase = 1'b1;
        next_pkg = '0;
        next_st = S_CFG;
      end else begin
        next_pkg = pkg + PKG_W'(1);
        next_cmd = CMD_CIS;
        next_st = S_SEND;
      end
    end
    // next channel during configuration
    if (do_ch_next) begin
      if (ch != CH_LAST) begin
        next_ch = ch + CH_W'(1);
        next_st = S_CH;
      end else if (!arb_active) begin
        next_cmd = CMD_DESELECT; // free the bus for the next
        next_st = S_SEND;
      end else begin
        do_cfg_next = 1'b1;
      end
    end
    // next package during configuration
    if (do_cfg_next) begin
      next_ch = '0;
      if (pkg == PKG_LAST) begin
        next_st = S_DONE;
      end else begin
        next_pkg = pkg + PKG_W'(1);
        next_st = S_CFG;
      end
    end
  end

  // sequencer registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= S_PWR;
      cmd <= CMD_CIS;
      pkg <= '0;
      ch <= '0;
      tries <= '0;
      tmr <= '0;
      cfg_phase <= 1'b0;
      arb_ok <= {NPKG{ARB_OK_RST}};
      arb_active <= 1'b0;
      done <= 1'b0;
      pkg_present <= '0;
      ch_present <= '0;
      link.cmd_valid <= 1'b0;
      link.cmd_code <= CMD_CIS;
      link.cmd_pkg <= '0;
      link.cmd_ch <= '0;
      link.cmd_arb <= 1'b0;
    end else begin
      st <= next_st;
      cmd <= next_cmd;
      pkg <= next_pkg;
      ch <= next_ch;
      tries <= next_tries;
      tmr <= next_tmr;
      cfg_phase <= next_cfg_phase;
      arb_ok <= next_arb_ok;
      arb_active <= next_arb_active;
      done <= next_done;
      pkg_present <= next_pkg_present;
      ch_present <= next_ch_present;
      link.cmd_valid <= next_cmd_valid;
      link.cmd_code <= next_cmd_code;
      link.cmd_pkg <= next_cmd_pkg;
      link.cmd_ch <= next_cmd_ch;
      link.cmd_arb <= next_cmd_arb;
    end
  end

  // pass-through and events bypass the sequencer entirely
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.pt_tx_valid <= 1'b0;
      link.pt_tx_data <= '0;
      pt_in_valid <= 1'b0;
      pt_in_data <= '0;
      aen_seen <= 1'b0;
      aen_pkg_seen <= '0;
      aen_code_seen <= '0;
    end else begin
      link.pt_tx_valid <= pt_out_valid;
      link.pt_tx_data <= pt_out_data;
      pt_in_valid <= link.pt_rx_valid;
      pt_in_data <= link.pt_rx_data;
      aen_seen <= link.aen_valid;
      aen_pkg_seen <= link.aen_pkg;
      aen_code_seen <= link.aen_code;
    end
  end
endmodule : sbds_mgmt_end

/* File: sbds_link_monitor.sv */
// assertions watching the first sideband link
`timescale 1ns/1ps
module sbds_link_monitor import sbds_pkg::*; #(
  parameter int unsigned PWRUP_CYCLES = 4, // ready wait
  parameter int unsigned MAX_TRIES = 3 // sends per command
) (
  input wire logic sys_clk, // clock
  input wire logic reset_n, // reset, active low
  input wire logic cmd_valid, // command strobe
  input sbds_cmd_e cmd_code, // command
  input wire logic [PKG_W-1:0] cmd_pkg, // package
  input wire logic [CH_W-1:0] cmd_ch, // channel
  input wire logic cmd_arb, // arbitration bit
  input wire logic rsp_valid, // response strobe
  input wire logic [PKG_W-1:0] rsp_pkg, // package
  input wire logic [CH_W-1:0] rsp_ch, // channel
  input wire logic aen_valid // event strobe
);
  int unsigned up, next_up; // cycles since reset
  int unsigned tries, next_tries; // sends of one command
  logic ans, next_ans; // last command answered
  logic sel, next_sel; // package left selected
  logic ena, next_ena; // some channel enabled
  logic [7:0] last, next_last; // last command sent
  // history; a response ends the retry run
  always_comb begin
    next_up = (up > PWRUP_CYCLES) ? up : up + 1;
    next_tries = tries;
    next_ans = ans | rsp_valid;
    next_sel = sel;
    next_ena = ena;
    next_last = last;
    if (cmd_valid) begin
      next_last = {cmd_code, cmd_pkg, cmd_ch};
      next_tries = (next_last == last && !ans) ? tries + 1 : 1;
      next_ans = 1'h0;
      if (cmd_code == CMD_SELECT) next_sel = 1'h1;
      if (cmd_code == CMD_DESELECT) next_sel = 1'h0;
      if (cmd_code == CMD_ENABLE_CH) next_ena = 1'h1;
    end
  end
  // ans starts high so the first send counts as fresh
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      up <= 0;
      tries <= 0;
      ans <= 1'h1;
      sel <= 1'h0;
      ena <= 1'h0;
      last <= 8'h00;
    end else begin
      up <= next_up;
      tries <= next_tries;
      ans <= next_ans;
      sel <= next_sel;
      ena <= next_ena;
      last <= next_last;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_rsp_cmd; rsp_valid |-> $past(cmd_valid); endproperty
  a_rsp_cmd: assert property (p_rsp_cmd)
    else $error("response without command");
  property p_echo;
    rsp_valid |-> rsp_pkg == $past(cmd_pkg) && rsp_ch == $past(cmd_ch);
  endproperty
  a_echo: assert property (p_echo)
    else $error("response ids differ from command");
  property p_gap; cmd_valid |=> !cmd_valid [*2]; endproperty
  a_gap: assert property (p_gap)
    else $error("command sent while one is outstanding");
  property p_arb_off; cmd_valid && cmd_code == CMD_SELECT |-> !cmd_arb;
  endproperty
  a_arb_off: assert property (p_arb_off)
    else $error("select with arbitration on");
  property p_one_sel; cmd_valid && cmd_code == CMD_SELECT |-> !sel;
  endproperty
  a_one_sel: assert property (p_one_sel)
    else $error("second package selected");
  property p_pwr; cmd_valid |-> up >= PWRUP_CYCLES; endproperty
  a_pwr: assert property (p_pwr)
    else $error("command inside ready wait");
  property p_retry;
    cmd_valid && !ans |->
      ({cmd_code, cmd_pkg, cmd_ch} == last) == (tries < MAX_TRIES);
  endproperty
  a_retry: assert property (p_retry)
    else $error("wrong resend count");
  property p_aen; aen_valid |-> ena; endproperty
  a_aen: assert property (p_aen)
    else $error("event before any channel enabled");
endmodule : sbds_link_monitor

/* File: sideband_discovery_sequencer_tb.sv */
// bench: two links, discovery, pass-through and events
`timescale 1ns/1ps
module sideband_discovery_sequencer_tb import sbds_pkg::*;;
  localparam int unsigned PWR = 4; // short ready wait
  localparam int unsigned RSP = 4; // short response window
  logic sys_clk, reset_n, arb_known; // clock, reset, hint
  logic pt_out_valid, net_rx_valid, event_valid; // strobes
  logic [DATA_W-1:0] pt_out_data, net_rx_data; // bytes in
  logic [CH_W-1:0] event_ch; // event channel
  logic [AEN_W-1:0] event_code; // event code
  logic [1:0] done, arb; // index 1 is the second link
  logic pin_v, ntx_v, aen, sel; // first link outputs
  logic [DATA_W-1:0] pin_d, ntx_d; // bytes out
  logic [PKG_W-1:0] apkg; // notifying package
  logic [AEN_W-1:0] acode; // event code seen
  logic [NUM_CH-1:0] en, init; // channel states
  logic [NUM_PKG-1:0] pkg_p [2]; // packages found
  logic [NUM_PKG*NUM_CH-1:0] ch_p [2]; // channels found
  int seed, fail_count, comparisons; // seed and counters
  sbds_link_if la(); // checked link
  sbds_link_if lb(); // link to an arbitrating controller
  sbds_mgmt_end #(.PWRUP_CYCLES(PWR), .RSP_CYCLES(RSP)) u_sbds_mgmt_end (
    .sys_clk(sys_clk), .reset_n(reset_n), .link(la), .arb_known(arb_known),
    .pt_out_valid(pt_out_valid), .pt_out_data(pt_out_data),
    .pt_in_valid(pin_v), .pt_in_data(pin_d), .aen_seen(aen),
    .aen_pkg_seen(apkg), .aen_code_seen(acode), .done(done[0]),
    .arb_active(arb[0]), .pkg_present(pkg_p[0]), .ch_present(ch_p[0]));
  sbds_nc_end #(.PKG_ID(3'h2), .CH_NUM(2), .ARB_CAP(1'h0)) u_sbds_nc_end (
    .sys_clk(sys_clk), .reset_n(reset_n), .link(la),
    .net_rx_valid(net_rx_valid), .net_rx_data(net_rx_data),
    .net_tx_valid(ntx_v), .net_tx_data(ntx_d), .event_valid(event_valid),
    .event_ch(event_ch), .event_code(event_code), .selected(sel),
    .arb_en(), .ch_enabled(en), .ch_initial(init));
  // second link: arbitration learnt from answers, then given as a hint
  sbds_mgmt_end #(.PWRUP_CYCLES(PWR), .RSP_CYCLES(RSP)) u_sbds_mgmt_end_b (
    .sys_clk(sys_clk), .reset_n(reset_n), .link(lb), .arb_known(arb_known),
    .pt_out_valid(pt_out_valid), .pt_out_data(pt_out_data),
    .pt_in_valid(), .pt_in_data(), .aen_seen(), .aen_pkg_seen(),
    .aen_code_seen(), .done(done[1]), .arb_active(arb[1]),
    .pkg_present(pkg_p[1]), .ch_present(ch_p[1]));
  sbds_nc_end #(.PKG_ID(3'h5), .CH_NUM(1)) u_sbds_nc_end_b (
    .sys_clk(sys_clk), .reset_n(reset_n), .link(lb),
    .net_rx_valid(net_rx_valid), .net_rx_data(net_rx_data),
    .net_tx_valid(), .net_tx_data(), .event_valid(event_valid),
    .event_ch(event_ch), .event_code(event_code), .selected(),
    .arb_en(), .ch_enabled(), .ch_initial());
  sbds_link_monitor #(.PWRUP_CYCLES(PWR)) u_sbds_link_monitor (
    .sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(la.cmd_valid),
    .cmd_code(la.cmd_code), .cmd_pkg(la.cmd_pkg), .cmd_ch(la.cmd_ch),
    .cmd_arb(la.cmd_arb), .rsp_valid(la.rsp_valid), .rsp_pkg(la.rsp_pkg),
    .rsp_ch(la.rsp_ch), .aen_valid(la.aen_valid));
  // free-running 200 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // one comparison, counted
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // expected channel map: n channels from id 0 in package p
  function automatic logic [31:0] chmap(input int p, n);
    chmap = '0;
    for (int i = 0; i < n; i++) chmap[p * NUM_CH + i] = 1'h1;
  endfunction : chmap
  // six-cycle reset, hint set while held
  task automatic rst(input logic k);
    @(posedge sys_clk);
    reset_n <= 1'h0;
    arb_known <= k;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'h1;
  endtask : rst
  // bounded wait, then inventory and end state
  task automatic disc(input logic k);
    for (int n = 0; n < 3000 && done !== 2'h3; n++) @(posedge sys_clk);
    #1;
    chk("done", done, 2'h3);
    chk("a pkg", pkg_p[0], 8'h04);
    chk("a ch", ch_p[0], chmap(2, 2));
    chk("a arb", arb[0], k);
    chk("a sel", sel, k);
    chk("a en", en, 4'h3);
    chk("a init", init, 4'hC);
    chk("b pkg", pkg_p[1], 8'h20);
    chk("b ch", ch_p[1], chmap(5, 1));
    chk("b arb", arb[1], 1'h1);
  endtask : disc
  // random byte each way; two ends add two cycles
  task automatic pt(input logic e);
    logic [7:0] d;
    d = 8'($random(seed));
    @(posedge sys_clk);
    {pt_out_valid, net_rx_valid} <= 2'h3;
    {pt_out_data, net_rx_data} <= {d, ~d};
    @(posedge sys_clk);
    {pt_out_valid, net_rx_valid} <= 2'h0;
    @(posedge sys_clk);
    #1;
    chk("tx", {ntx_v, pin_v}, {e, e});
    if (e) chk("tx data", {ntx_d, pin_d}, {d, ~d});
  endtask : pt
  // one event pulse; expect a notice two cycles on or none
  task automatic ev(input logic [1:0] ch, input logic e);
    logic [3:0] c;
    c = 4'($random(seed));
    @(posedge sys_clk);
    {event_valid, event_ch, event_code} <= {1'h1, ch, c};
    @(posedge sys_clk);
    event_valid <= 1'h0;
    @(posedge sys_clk);
    #1;
    chk("aen", aen, e);
    if (e) chk("aen data", {apkg, acode}, {3'h2, c});
  endtask : ev
  // verdict, reached from the sequence or the watchdog
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // hang guard: whole run is a few hundred cycles
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
  // unknown arbitration, then known, with a reset between
  initial begin
    seed = 43044;
    fail_count = 0;
    comparisons = 0;
    {reset_n, arb_known, pt_out_valid, net_rx_valid, event_valid} = '0;
    {pt_out_data, net_rx_data, event_ch, event_code} = '0;
    rst(1'h0);
    ev(2'h0, 1'h0);
    disc(1'h0);
    repeat (4) pt(1'h0);
    $display("test unknown arbitration finished");
    rst(1'h1);
    disc(1'h1);
    repeat (4) pt(1'h1);
    for (int i = 0; i < 4; i++) ev(2'(i), i < 2);
    $display("test known arbitration finished");
    summarize();
  end
endmodule : sideband_discovery_sequencer_tb
